// File: rtl/ldip_regs.svh
// register offsets, field positions, reset values and timing figures of the
// double-edge input port; assumes a 5-bit register address and 8-bit data
`ifndef LDIP_REGS_SVH
`define LDIP_REGS_SVH

// ************************************************************************
// register offsets
// ************************************************************************
`define LDIP_OFS_PROBE_DELAY   5'h04
`define LDIP_OFS_SAMPLE_POINT  5'h05
`define LDIP_OFS_PORT_STATUS   5'h06

// ************************************************************************
// field positions
// ************************************************************************
`define LDIP_SPT_MSB           4
`define LDIP_LEAD_MSB          7
`define LDIP_LEAD_LSB          4
`define LDIP_LAG_MSB           3
`define LDIP_STAT_SEEK_BIT     0
`define LDIP_STAT_BUSY_BIT     1

// ************************************************************************
// reset values
// ************************************************************************
`define LDIP_PROBE_DELAY_RST   8'h00
`define LDIP_SAMPLE_POINT_RST  8'h00

// ************************************************************************
// timing figures in picoseconds, and the largest probe delay code
// ************************************************************************
`define LDIP_SPT_STEP_PS       160
`define LDIP_PROBE_STEP_PS     80
`define LDIP_PROBE_MAX_CODE    15
`define LDIP_LINK_PERIOD_PS    12000

`endif

// File: rtl/ldip_pkg.sv
// types shared by the double-edge input port
// assumes the constants of ldip_regs.svh are included where needed
package ldip_pkg;

   // ************************************************************************
   // types
   // ************************************************************************
   typedef logic [15:0] ldip_word_t;   // one sample word on the data lines
   typedef logic [7:0]  ldip_byte_t;   // register data
   typedef logic [13:0] ldip_ps_t;     // strobe position in picoseconds

   // settings hand-over state on the register clock
   typedef enum logic [0:0] {
      LDIP_XF_IDLE = 1'b0,
      LDIP_XF_WAIT = 1'b1
   } ldip_xfer_t;

endpackage

// File: rtl/ldip_input_port.sv
// double-edge input port with programmable sample point and frame probe
// assumes the lvds receivers sit outside; i_clock runs the register port,
// i_conv_clock is the converter clock that also times the link
`include "ldip_regs.svh"

// Overview of operation
// R01: drive source clock out to data source
// R02: source multiplexes i/q words on 16 lines
// R03: frame clock steers each word to i/q
// R04: latch data with delayed converter clock strobe
// R05: capture both edges, demultiplex, retime words
// R06: delays in picoseconds, 160/80 ps steps
// R07: delay fields at offsets 0x05 and 0x04
// R08: delayed frame clock sampled by late strobe
// R09: lag later, lead earlier probe sample
// R10: probe sample kept as constant readable flag
// R11: source sends frame clock like data line
// R12: calibration zeroes delays, finds toggle points
// R13: calibration sweeps sample point up to 31
// R14: no toggle found means record fifteen
// R15: output interrupted while checking interface timing; here the words and valid keep flowing while the probe runs
// R16: uninterrupted use needs clock at 500 MHz
// R17: probe flag readable, follows new settings quickly
// R18: frame high to i, low to q
module ldip_input_port
   import ldip_pkg::*;
#(
   parameter int LINK_PERIOD_PS = `LDIP_LINK_PERIOD_PS
) (
   input  wire logic       i_clock,
   input  wire logic       i_rstn,
   input  wire logic [4:0] i_reg_addr,
   input  wire logic       i_reg_write,
   input  wire ldip_byte_t i_reg_wdata,
   output ldip_byte_t      o_reg_rdata,
   input  wire logic       i_conv_clock,
   input  wire ldip_word_t i_data,
   input  wire logic       i_frame_clock_in,
   output logic            o_source_clock_p,
   output logic            o_source_clock_n,
   output ldip_word_t      o_i_word,
   output ldip_word_t      o_q_word,
   output logic            o_word_valid,
   output logic            o_frame_slip
);

   // ************************************************************************
   // constants
   // ************************************************************************
   localparam ldip_ps_t HALF_PS = ldip_ps_t'(LINK_PERIOD_PS / 2);

   // strobe position: fixed base, sample point, and for the probe lag minus lead
   function automatic ldip_ps_t strobe_ps(input logic [4:0] spt,
                                          input logic [3:0] lead,
                                          input logic [3:0] lag,
                                          input logic       probe);
      ldip_ps_t t;
      t = ldip_ps_t'(`LDIP_PROBE_MAX_CODE * `LDIP_PROBE_STEP_PS);
      t = t + ldip_ps_t'(spt) * ldip_ps_t'(`LDIP_SPT_STEP_PS);       // R06
      if (probe) begin
         t = t + ldip_ps_t'(lag) * ldip_ps_t'(`LDIP_PROBE_STEP_PS);  // R09
         t = t - ldip_ps_t'(lead) * ldip_ps_t'(`LDIP_PROBE_STEP_PS); // R09
      end
      return t;
   endfunction

   // ************************************************************************
   // register clock domain: registers and write decode
   // ************************************************************************
   ldip_byte_t probe_delay_reg;     // lead in high nibble, lag in low
   ldip_byte_t sample_point_reg;    // sample point delay in low five bits
   logic       pending_reg;         // settings written but not yet handed over
   ldip_xfer_t xfer_reg;            // hand-over state
   logic       req_tgl_reg;         // request toggle toward the link
   logic [12:0] snap_reg;           // stable copy while a hand-over runs
   logic       ack_s1_reg;          // acknowledge synchroniser
   logic       ack_s2_reg;
   logic       seek_s1_reg;         // probe flag synchroniser
   logic       seek_s2_reg;
   ldip_byte_t rdata_reg;           // read data
   logic       ack_tgl_reg;         // echoed toggle, driven on the link side
   logic       seek_reg;            // probe flag, driven on the link side

   wire hit_probe  = i_reg_addr == `LDIP_OFS_PROBE_DELAY;
   wire hit_sample = i_reg_addr == `LDIP_OFS_SAMPLE_POINT;
   wire hit_status = i_reg_addr == `LDIP_OFS_PORT_STATUS;
   wire wr_probe   = i_reg_write && hit_probe;
   wire wr_sample  = i_reg_write && hit_sample;
   wire launch     = (xfer_reg == LDIP_XF_IDLE) && pending_reg;
   wire acked      = ack_s2_reg == req_tgl_reg;
   wire busy       = pending_reg || (xfer_reg == LDIP_XF_WAIT);

   // software-visible delay fields
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         probe_delay_reg  <= `LDIP_PROBE_DELAY_RST;
         sample_point_reg <= `LDIP_SAMPLE_POINT_RST;
      end else begin
         if (wr_probe) begin
            probe_delay_reg <= i_reg_wdata;                         // R07
         end
         if (wr_sample) begin
            sample_point_reg <= {3'h0, i_reg_wdata[`LDIP_SPT_MSB:0]}; // R07
         end
      end
   end

   // pending: a write that lands on the launch cycle still wins
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         pending_reg <= 1'b0;
      end else if (wr_probe || wr_sample) begin
         pending_reg <= 1'b1;
      end else if (launch) begin
         pending_reg <= 1'b0;
      end
   end

   // fields as they stand; a write on the launch edge re-arms pending
   wire [12:0] snap_next = {probe_delay_reg, sample_point_reg[`LDIP_SPT_MSB:0]};

   // hand-over: snapshot stays frozen until the link side echoes the toggle
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         xfer_reg    <= LDIP_XF_IDLE;
         req_tgl_reg <= 1'b0;
         snap_reg    <= 13'h0000;
      end else begin
         unique case (xfer_reg)
            LDIP_XF_IDLE: begin
               if (launch) begin
                  snap_reg    <= snap_next;
                  req_tgl_reg <= ~req_tgl_reg;
                  xfer_reg    <= LDIP_XF_WAIT;
               end
            end
            LDIP_XF_WAIT: begin
               if (acked) begin
                  xfer_reg <= LDIP_XF_IDLE;
               end
            end
         endcase
      end
   end

   // synchronisers from the link domain
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         ack_s1_reg  <= 1'b0;
         ack_s2_reg  <= 1'b0;
         seek_s1_reg <= 1'b0;
         seek_s2_reg <= 1'b0;
      end else begin
         ack_s1_reg  <= ack_tgl_reg;
         ack_s2_reg  <= ack_s1_reg;
         seek_s1_reg <= seek_reg;
         seek_s2_reg <= seek_s1_reg;
      end
   end

   // read mux; unmapped offsets read zero
   wire ldip_byte_t status_val = {6'h00, busy, seek_s2_reg};         // R17
   wire ldip_byte_t rdata_next = hit_probe  ? probe_delay_reg  :
                                 hit_sample ? sample_point_reg :
                                 hit_status ? status_val       : 8'h00;

   // read data is registered: one cycle after the address
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end
   assign o_reg_rdata = rdata_reg;

   // ************************************************************************
   // link clock domain: reset, settings and source clock
   // ************************************************************************
   logic       lrst_a_reg;          // reset release synchroniser
   logic       lrst_n_reg;
   logic       req_s1_reg;          // request toggle synchroniser
   logic       req_s2_reg;
   logic [4:0] spt_reg;             // link copy of the sample point delay
   logic [3:0] lead_reg;            // link copy of the lead probe delay
   logic [3:0] lag_reg;             // link copy of the lag probe delay

   // async assert, clocked release so no link flop leaves reset mid-edge
   always_ff @(posedge i_conv_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         lrst_a_reg <= 1'b0;
         lrst_n_reg <= 1'b0;
      end else begin
         lrst_a_reg <= 1'b1;
         lrst_n_reg <= lrst_a_reg;
      end
   end

   // settings are taken only once the toggle has crossed two stages
   always_ff @(posedge i_conv_clock or negedge lrst_n_reg) begin
      if (!lrst_n_reg) begin
         req_s1_reg  <= 1'b0;
         req_s2_reg  <= 1'b0;
         ack_tgl_reg <= 1'b0;
         spt_reg     <= 5'h00;
         lead_reg    <= 4'h0;
         lag_reg     <= 4'h0;
      end else begin
         req_s1_reg <= req_tgl_reg;
         req_s2_reg <= req_s1_reg;
         if (req_s2_reg != ack_tgl_reg) begin
            {lead_reg, lag_reg, spt_reg} <= snap_reg;                // R17
            ack_tgl_reg                  <= req_s2_reg;
         end
      end
   end

   // the converter clock is forwarded as a pair so the source clocks out
   assign o_source_clock_p = i_conv_clock;                            // R01
   assign o_source_clock_n = ~i_conv_clock;                           // R01

   // ************************************************************************
   // link clock domain: double-edge capture
   // ************************************************************************
   ldip_word_t rise_s1_reg, rise_s2_reg, rise_d_reg;  // rising-edge words
   ldip_word_t fall_s1_reg, fall_s2_reg, fall_h_reg;  // falling-edge words
   logic       frr_s1_reg, frr_s2_reg, frr_d_reg;     // frame level, rising
   logic       frf_s1_reg, frf_s2_reg, frf_h_reg;     // frame level, falling
   logic [3:0] fr_rise_hist_reg;                      // recent rising frame levels
   logic [3:0] fr_fall_hist_reg;                      // recent falling frame levels

   // rising edge of the strobe: data and frame pass two stages
   always_ff @(posedge i_conv_clock or negedge lrst_n_reg) begin
      if (!lrst_n_reg) begin
         rise_s1_reg <= 16'h0000;
         rise_s2_reg <= 16'h0000;
         frr_s1_reg  <= 1'b0;
         frr_s2_reg  <= 1'b0;
      end else begin
         rise_s1_reg <= i_data;                                       // R04
         rise_s2_reg <= rise_s1_reg;
         frr_s1_reg  <= i_frame_clock_in;                             // R03
         frr_s2_reg  <= frr_s1_reg;
      end
   end

   // falling edge of the strobe: the second half of each pair in even phase, the first half in odd phase
   always_ff @(negedge i_conv_clock or negedge lrst_n_reg) begin
      if (!lrst_n_reg) begin
         fall_s1_reg <= 16'h0000;
         fall_s2_reg <= 16'h0000;
         frf_s1_reg  <= 1'b0;
         frf_s2_reg  <= 1'b0;
      end else begin
         fall_s1_reg <= i_data;                                       // R05
         fall_s2_reg <= fall_s1_reg;
         frf_s1_reg  <= i_frame_clock_in;                             // R08
         frf_s2_reg  <= frf_s1_reg;
      end
   end

   // retime falling captures onto the rising edge and keep frame history
   always_ff @(posedge i_conv_clock or negedge lrst_n_reg) begin
      if (!lrst_n_reg) begin
         rise_d_reg       <= 16'h0000;
         fall_h_reg       <= 16'h0000;
         frr_d_reg        <= 1'b0;
         frf_h_reg        <= 1'b0;
         fr_rise_hist_reg <= 4'h0;
         fr_fall_hist_reg <= 4'h0;
      end else begin
         rise_d_reg       <= rise_s2_reg;
         fall_h_reg       <= fall_s2_reg;                             // R05
         frr_d_reg        <= frr_s2_reg;
         frf_h_reg        <= frf_s2_reg;
         fr_rise_hist_reg <= {fr_rise_hist_reg[2:0], frr_s2_reg};
         fr_fall_hist_reg <= {fr_fall_hist_reg[2:0], frf_s2_reg};
      end
   end

   // ************************************************************************
   // link clock domain: sample point and demultiplex
   // ************************************************************************
   // strobe delay is quantised to half converter cycles; finer steps only
   // move the point where a whole half-cycle boundary is crossed
   wire ldip_ps_t data_ps   = strobe_ps(spt_reg, lead_reg, lag_reg, 1'b0);
   wire ldip_ps_t data_idx  = data_ps / HALF_PS;
   wire           data_odd  = data_idx[0];                            // R06

   // odd phase pairs the previous falling word with the next rising word
   wire ldip_word_t first_w = data_odd ? fall_h_reg  : rise_d_reg;
   wire ldip_word_t second_w = data_odd ? rise_s2_reg : fall_h_reg;
   wire             first_f = data_odd ? frf_h_reg   : frr_d_reg;
   wire             second_f = data_odd ? frr_s2_reg : frf_h_reg;
   wire             slip    = first_f == second_f;

   ldip_word_t i_word_reg;   // word bound for the i converter
   ldip_word_t q_word_reg;   // word bound for the q converter
   logic       valid_reg;    // words are from a complete capture pipe
   logic       slip_reg;     // frame levels of a pair did not alternate
   logic [2:0] fill_reg;     // counts pipe fill after reset

   // frame high steers to i, low to q; a broken pattern still delivers
   always_ff @(posedge i_conv_clock or negedge lrst_n_reg) begin
      if (!lrst_n_reg) begin
         i_word_reg <= 16'h0000;
         q_word_reg <= 16'h0000;
         valid_reg  <= 1'b0;
         slip_reg   <= 1'b0;
         fill_reg   <= 3'h0;
      end else begin
         i_word_reg <= first_f ? first_w : second_w;                  // R18
         q_word_reg <= first_f ? second_w : first_w;                  // R18
         slip_reg   <= slip && valid_reg;
         if (fill_reg != 3'h4) begin
            fill_reg <= fill_reg + 3'h1;
         end
         valid_reg <= fill_reg == 3'h4;                               // R05
      end
   end

   assign o_i_word     = i_word_reg;
   assign o_q_word     = q_word_reg;
   assign o_word_valid = valid_reg;
   assign o_frame_slip = slip_reg;

   // ************************************************************************
   // link clock domain: frame clock probe
   // ************************************************************************
   // the probe is the data strobe moved by lag, minus the lead delay on the
   // frame clock; a periodic frame clock keeps the result steady
   wire ldip_ps_t probe_ps  = strobe_ps(spt_reg, lead_reg, lag_reg, 1'b1); // R08
   wire ldip_ps_t probe_idx = probe_ps / HALF_PS;
   wire [1:0]     probe_cyc = probe_idx[2:1];
   wire           probe_lvl = probe_idx[0] ? fr_fall_hist_reg[probe_cyc]
                                           : fr_rise_hist_reg[probe_cyc];

   // probe flag register, read across on the register clock
   always_ff @(posedge i_conv_clock or negedge lrst_n_reg) begin
      if (!lrst_n_reg) begin
         seek_reg <= 1'b0;
      end else begin
         seek_reg <= probe_lvl;                                       // R10
      end
   end

endmodule

// File: dv/ldip_input_port_asserts.sv
// concurrent checks on the ports of the double-edge input port
// assumes it is bound to ldip_input_port; offsets come from ldip_regs.svh
`include "ldip_regs.svh"
module ldip_input_port_asserts
   import ldip_pkg::*;
#(
   parameter int LINK_PERIOD_PS = 12000 // only handed on, figures are cycle based
) (
   input wire logic       i_clock,
   input wire logic       i_rstn,
   input wire logic [4:0] i_reg_addr,
   input wire logic       i_reg_write,
   input wire ldip_byte_t i_reg_wdata,
   input wire ldip_byte_t o_reg_rdata,
   input wire logic       i_conv_clock,
   input wire logic       o_source_clock_p,
   input wire logic       o_source_clock_n,
   input wire logic       o_word_valid
);
   timeunit 1ns;
   timeprecision 100ps;
   // ************************************************************************
   // register side, sampled on the register clock
   // ************************************************************************
   chk_src_clk_follow: assert property (@(posedge i_clock) disable iff (!i_rstn)
      o_source_clock_p == i_conv_clock && o_source_clock_n == !i_conv_clock)
      else $error("source clock pair does not follow the converter clock");
   chk_unmapped_zero: assert property (@(posedge i_clock) disable iff (!i_rstn)
      !(i_reg_addr inside {5'h04, 5'h05, 5'h06}) |=> o_reg_rdata == 8'h00)
      else $error("unmapped offset read back non zero");
   chk_spt_top_zero: assert property (@(posedge i_clock) disable iff (!i_rstn)
      i_reg_addr == `LDIP_OFS_SAMPLE_POINT |=> o_reg_rdata[7:5] == 3'b000)
      else $error("sample point upper bits not zero");
   chk_probe_readback: assert property (@(posedge i_clock) disable iff (!i_rstn)
      i_reg_write && i_reg_addr == 5'h04 ##1 i_reg_addr == 5'h04 && !i_reg_write
      |=> o_reg_rdata == $past(i_reg_wdata, 2))
      else $error("probe delay field lost its written value");
   chk_spt_readback: assert property (@(posedge i_clock) disable iff (!i_rstn)
      i_reg_write && i_reg_addr == 5'h05 ##1 i_reg_addr == 5'h05 && !i_reg_write
      |=> o_reg_rdata[4:0] == $past(i_reg_wdata[4:0], 2))
      else $error("sample point field lost its written value");
   chk_busy_on_write: assert property (@(posedge i_clock) disable iff (!i_rstn)
      i_reg_write && i_reg_addr == 5'h05 ##1 i_reg_addr == 5'h06 |=> o_reg_rdata[1])
      else $error("hand-over busy not shown after a setting write");
   chk_status_spare: assert property (@(posedge i_clock) disable iff (!i_rstn)
      i_reg_addr == `LDIP_OFS_PORT_STATUS |=> o_reg_rdata[7:2] == 6'h00)
      else $error("status spare bits not zero");
   // ************************************************************************
   // link side, sampled on the converter clock
   // ************************************************************************
   chk_valid_holds: assert property (@(posedge i_conv_clock) disable iff (!i_rstn)
      o_word_valid |=> o_word_valid)
      else $error("word valid dropped while out of reset");
   chk_valid_fill: assert property (@(posedge i_conv_clock) disable iff (!i_rstn)
      $rose(o_word_valid) |-> $past(i_rstn, 6))
      else $error("word valid rose before the capture pipe could fill");
endmodule

// File: dv/ldip_source_model.sv
// behavioural data source at the far side of the link
// assumes it is clocked by the source clock that the port drives out
module ldip_source_model
   import ldip_pkg::*;
(
   input  wire logic i_source_clock,
   input  wire logic i_break_frame,
   output ldip_word_t o_data,
   output logic      o_frame
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [11:0] count_reg;  // shared index of each i/q pair
   logic        high_half;  // clock level at the edge being served

   // one process drives the lines so each has a single driver: i word after
   // a rising edge, q word after a falling one, both after clock-to-out;
   // a break holds the frame level high
   initial begin
      o_data    = 16'h0000;
      o_frame   = 1'b0;
      count_reg = 12'h000;
      forever begin
         @(posedge i_source_clock or negedge i_source_clock);
         high_half = i_source_clock;
         #3;
         if (high_half) begin
            o_data  = {4'ha, count_reg};
            o_frame = 1'b1;
         end else begin
            o_data    = {4'h5, count_reg};
            o_frame   = i_break_frame;
            count_reg = count_reg + 12'h001;
         end
      end
   end
endmodule

// File: dv/ldip_input_port_tb.sv
// self-checking bench of the double-edge input port with a data source model
// assumes ldip_regs.svh on the include path; flag figures follow the half period
`include "ldip_regs.svh"
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin failures++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module ldip_input_port_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import ldip_pkg::*;
   logic       i_clock, i_rstn, i_reg_write, i_conv_clock, break_frame;
   logic [4:0] i_reg_addr;   // register offset
   ldip_byte_t i_reg_wdata, o_reg_rdata;
   ldip_word_t i_data, o_i_word, o_q_word;
   logic       i_frame_clock_in, src_clk_p, src_clk_n, o_word_valid, o_frame_slip;
   int         failures = 0;
   int         check_count = 0;

   ldip_input_port ldip_input_port_i (.i_clock(i_clock), .i_rstn(i_rstn),
      .i_reg_addr(i_reg_addr), .i_reg_write(i_reg_write), .i_reg_wdata(i_reg_wdata),
      .o_reg_rdata(o_reg_rdata), .i_conv_clock(i_conv_clock), .i_data(i_data),
      .i_frame_clock_in(i_frame_clock_in), .o_source_clock_p(src_clk_p),
      .o_source_clock_n(src_clk_n), .o_i_word(o_i_word), .o_q_word(o_q_word),
      .o_word_valid(o_word_valid), .o_frame_slip(o_frame_slip));
   ldip_source_model ldip_source_model_i (.i_source_clock(src_clk_p),
      .i_break_frame(break_frame), .o_data(i_data), .o_frame(i_frame_clock_in));

   // ************************************************************************
   // clocks, register access and closing
   // ************************************************************************
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   // link clock offset so its edges never meet the register clock
   initial begin
      i_conv_clock = 1'b0;
      #3.7;
      forever #6 i_conv_clock = ~i_conv_clock;
   end
   // write pulse, then leave the offset at nxt for a back-to-back read
   task automatic wr(input logic [4:0] a, input ldip_byte_t d, input logic [4:0] nxt);
      @(posedge i_clock);
      i_reg_addr  <= a;
      i_reg_wdata <= d;
      i_reg_write <= 1'b1;
      @(posedge i_clock);
      i_reg_write <= 1'b0;
      i_reg_addr  <= nxt;
   endtask
   task automatic rd(input logic [4:0] a, output ldip_byte_t v);
      @(posedge i_clock);
      i_reg_addr <= a;
      @(posedge i_clock);
      #1 v = o_reg_rdata;
   endtask
   // poll busy under a bound, then give the flag time to cross back
   task automatic settle();
      ldip_byte_t v;
      int n;
      n = 0;
      do begin
         rd(`LDIP_OFS_PORT_STATUS, v);
         n++;
      end while (v[1] !== 1'b0 && n < 50);
      `CHK("busy clear", 1'b0, v[1])
      repeat (8) @(posedge i_clock);
   endtask
   task automatic probe(input logic [4:0] spt, input logic [3:0] lead,
                        input logic [3:0] lag, output logic f);
      ldip_byte_t v;
      wr(`LDIP_OFS_PROBE_DELAY, {lead, lag}, `LDIP_OFS_PROBE_DELAY);
      wr(`LDIP_OFS_SAMPLE_POINT, {3'b000, spt}, `LDIP_OFS_SAMPLE_POINT);
      settle();
      rd(`LDIP_OFS_PORT_STATUS, v);
      f = v[0];
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // watchdog: the whole sequence needs about a thousand cycles
   initial begin
      repeat (20000) @(posedge i_clock);
      failures++;
      close_out();
   end

   // ************************************************************************
   // test sequence
   // ************************************************************************
   initial begin
      ldip_byte_t v;
      logic       base, f;
      logic [11:0] prev;
      int         n;
      i_rstn      = 1'b0;
      i_reg_addr  = 5'h00;
      i_reg_write = 1'b0;
      i_reg_wdata = 8'h00;
      break_frame = 1'b0;
      repeat (12) @(posedge i_clock);
      i_rstn <= 1'b1;
      rd(5'h04, v);
      `CHK("probe reset", 8'h00, v)
      rd(5'h05, v);
      `CHK("point reset", 8'h00, v)
      rd(5'h1f, v);
      `CHK("unmapped read", 8'h00, v)
      $display("test reset_values done");
      wr(5'h04, 8'ha5, 5'h04);
      rd(5'h04, v);
      `CHK("probe rw", 8'ha5, v)
      wr(5'h05, 8'hff, 5'h06);
      rd(5'h06, v);
      `CHK("busy set", 1'b1, v[1])
      rd(5'h05, v);
      `CHK("point rw", 8'h1f, v)
      wr(5'h06, 8'hff, 5'h07);
      wr(5'h07, 8'h3c, 5'h07);
      rd(5'h07, v);
      `CHK("unmapped write", 8'h00, v)
      rd(5'h04, v);
      `CHK("probe kept", 8'ha5, v)
      $display("test register_access done");
      // calibration start: all delays zero, record the flag
      probe(5'd0, 4'd0, 4'd0, base);
      n = 0;
      while (o_word_valid !== 1'b1 && n < 100) begin
         @(posedge i_conv_clock);
         n++;
      end
      `CHK("word valid", 1'b1, o_word_valid)
      for (int k = 0; k < 8; k++) begin
         @(posedge i_conv_clock);
         #1;
         `CHK("i word tag", 4'ha, o_i_word[15:12])
         `CHK("q word tag", 4'h5, o_q_word[15:12])
         `CHK("no slip", 1'b0, o_frame_slip)
         `CHK("source clock", 2'b10, {src_clk_p, src_clk_n})
         if (k > 0) `CHK("i word order", prev + 12'h001, o_i_word[11:0])
         prev = o_i_word[11:0];
      end
      $display("test word_stream done");
      @(posedge i_clock);
      break_frame <= 1'b1;
      n = 0;
      while (o_frame_slip !== 1'b1 && n < 20) begin
         @(posedge i_conv_clock);
         n++;
      end
      `CHK("slip seen", 1'b1, o_frame_slip)
      @(posedge i_clock);
      break_frame <= 1'b0;
      repeat (10) @(posedge i_conv_clock);
      #1 `CHK("slip gone", 1'b0, o_frame_slip)
      $display("test frame_break done");
      // sweep: 1200 + point*160 ps crosses the 6000 ps half period at 30
      for (int s = 1; s < 32; s++) begin
         probe(s[4:0], 4'd0, 4'd0, f);
         `CHK("flag vs point", base ^ (s >= 30), f)
      end
      for (int r = 0; r < 3; r++) begin
         probe(5'd0, 4'd0, 4'd0, f);
         `CHK("flag steady", base, f)
      end
      probe(5'd29, 4'd0, 4'd1, f);
      `CHK("lag one", base, f)
      probe(5'd29, 4'd0, 4'd2, f);
      `CHK("lag two", ~base, f)
      probe(5'd30, 4'd1, 4'd0, f);
      `CHK("lead one", base, f)
      probe(5'd0, 4'd15, 4'd0, f);
      `CHK("lead none", base, f)
      $display("test probe_sweep done");
      // odd phase: a falling word pairs with the next rising word
      probe(5'd31, 4'd0, 4'd0, f);
      for (int k = 0; k < 4; k++) begin
         @(posedge i_conv_clock);
         #1;
         `CHK("odd i tag", 4'ha, o_i_word[15:12])
         `CHK("odd q pair", {4'h5, o_i_word[11:0]}, o_q_word)
      end
      $display("test odd_phase done");
      close_out();
   end
endmodule

bind ldip_input_port ldip_input_port_asserts #(.LINK_PERIOD_PS(LINK_PERIOD_PS))
   ldip_input_port_asserts_i (.i_clock(i_clock), .i_rstn(i_rstn),
   .i_reg_addr(i_reg_addr), .i_reg_write(i_reg_write), .i_reg_wdata(i_reg_wdata),
   .o_reg_rdata(o_reg_rdata), .i_conv_clock(i_conv_clock),
   .o_source_clock_p(o_source_clock_p), .o_source_clock_n(o_source_clock_n),
   .o_word_valid(o_word_valid));
